/* design/temp_alarm_register_logic.sv */
`timescale 1ns/10ps
module temp_alarm_register_logic
    import temp_alarm_pkg::*;
#(
    parameter int          TEMP_W        = 12,
    parameter int unsigned FAST_INTERVAL = FAST_PERIOD_CYC,
    parameter logic [7:0]  MAKER_ID      = 8'h5A   // Arbitrary value
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [6:0]        slave_addr_i,
    input  wire logic              cmd_valid_i,
    input  wire logic [7:0]        cmd_byte_i,
    input  wire logic              wr_valid_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic              rd_req_i,
    output logic [7:0]             rd_data_o,
    input  wire logic              ara_req_i,
    output logic                   ara_ack_o,
    input  wire logic              ara_lost_i,
    input  wire logic              ara_done_i,
    output logic                   conv_start_o,
    output logic                   junction_type_sel_o,
    input  wire logic              conv_done_i,
    input  wire logic [TEMP_W-1:0] local_temp_i,
    input  wire logic [TEMP_W-1:0] remote_temp_i,
    input  wire logic              remote_open_i,
    input  wire logic              remote_short_i,
    output logic                   alert_o,
    output logic                   alert_oe_o,
    output logic                   overheat_out_a_o,
    output logic                   overheat_out_b_o
);

    // =====================================================================
    // Helpers
    localparam state_t RST = '{
        conv: CONV_RUN, start: 1'b1, timer: 32'h0000_0000, cmd: RST_CMD,
        loc: 8'h00, rem: 8'h00, loc_x: 8'h00, rem_x: 8'h00,
        cfg: RST_CFG, rate: RST_RATE,
        lhi: RST_HIGH_LIMIT, llo: RST_LOW_LIMIT,
        rhi: RST_HIGH_LIMIT, rlo: RST_LOW_LIMIT,
        rem_ot_a: RST_OT_LIMIT, loc_ot_a: RST_OT_LIMIT,
        rem_ot_b: RST_OT_LIMIT, loc_ot_b: RST_OT_LIMIT,
        overtemp_hysteresis: RST_OVERTEMP_HYSTERESIS, flags: 5'h00, cause: 5'h00, ot: 4'h0,
        alert: 1'b0, done_seen: 1'b0, rd_data: 8'h00};

    // Whole degrees, clamped into the 8-bit range
    function automatic logic [7:0] sat_main(input logic [TEMP_W-1:0] raw);
        logic signed [TEMP_W-1:0] deg;
        deg = $signed(raw) >>> FRAC_BITS;
        if (deg > $signed({{(TEMP_W-8){1'b0}}, MAIN_MAX})) begin
            return MAIN_MAX;
        end
        if (deg < $signed({{(TEMP_W-8){1'b1}}, MAIN_MIN})) begin
            return MAIN_MIN;
        end
        return deg[7:0];
    endfunction

    // Overheat flag with hysteresis: set at or above, release below limit-overtemp_hysteresis
    function automatic logic ot_next(input logic cur, input logic [7:0] rd,
                                     input logic [7:0] lim, input logic [7:0] hy);
        logic signed [9:0] low;
        low = $signed({{2{lim[7]}}, lim}) - $signed({{2{hy[7]}}, hy});
        if ($signed(rd) >= $signed(lim)) begin
            return 1'b1;
        end
        if ($signed({{2{rd[7]}}, rd}) < low) begin
            return 1'b0;
        end
        return cur;
    endfunction

    function automatic logic [31:0] interval(input logic [3:0] code);
        logic [31:0] base;
        base = 32'(FAST_INTERVAL);
        if (code >= RATE_FASTEST) begin
            return base;
        end
        return base << (RATE_FASTEST - code);
    endfunction

    state_t s_r;
    state_t s_nxt;

    logic       done_evt;
    logic       start_evt;
    logic       one_shot;
    logic [7:0] loc_new;
    logic [7:0] rem_new;
    logic [4:0] cause_new;
    logic       fault;

    assign done_evt  = conv_done_i && (s_r.conv == CONV_RUN);
    assign one_shot  = cmd_valid_i && (cmd_byte_i == CMD_ONE_SHOT);
    assign fault     = remote_open_i || remote_short_i;
    assign loc_new   = sat_main(local_temp_i);
    assign rem_new   = fault ? FAULT_CODE : sat_main(remote_temp_i);

    // Causes seen at the end of a conversion
    always_comb begin
        cause_new          = 5'h00;
        cause_new[FL_LHI]  = $signed(loc_new) >= $signed(s_r.lhi);
        cause_new[FL_LLO]  = $signed(loc_new) <= $signed(s_r.llo);
        cause_new[FL_RHI]  = $signed(rem_new) >= $signed(s_r.rhi);
        cause_new[FL_RLO]  = $signed(rem_new) <= $signed(s_r.rlo);
        cause_new[FL_OPEN] = remote_open_i;
    end

    // =====================================================================
    // Conversion sequencing
    always_comb begin
        start_evt = 1'b0;
        if (s_r.conv == CONV_IDLE || done_evt) begin
            // A one-shot in the same cycle as a conversion end falls through here
            if (one_shot && s_r.conv == CONV_IDLE) begin
                start_evt = 1'b1;
            end else if (!s_r.cfg[CFG_STBY] && s_r.timer >= interval(s_r.rate) - 32'd1) begin
                start_evt = 1'b1;
            end
        end
    end

    // =====================================================================
    // Next state
    always_comb begin
        logic [7:0] rdv;
        logic [7:0] status;
        rdv    = 8'h00;
        s_nxt  = s_r;
        status = {s_r.conv == CONV_RUN, s_r.flags, s_r.ot[1:0]};

        // Rate timer runs start to start; it never stalls on alerts
        s_nxt.start = 1'b0;
        if (s_r.cfg[CFG_STBY]) begin
            s_nxt.timer = 32'h0000_0000;
        end else if (s_r.timer < interval(s_r.rate) - 32'd1) begin
            s_nxt.timer = s_r.timer + 32'd1;
        end

        if (done_evt) begin
            s_nxt.conv  = CONV_IDLE;
            s_nxt.loc   = loc_new;
            s_nxt.rem   = rem_new;
            s_nxt.loc_x = {local_temp_i[FRAC_BITS-1:0], 5'b0_0000};
            s_nxt.rem_x = fault ? 8'h00 : {remote_temp_i[FRAC_BITS-1:0], 5'b0_0000};
            s_nxt.cause = cause_new;
            s_nxt.done_seen = 1'b1;
        end
        if (start_evt) begin
            s_nxt.conv  = CONV_RUN;
            s_nxt.start = 1'b1;
            s_nxt.timer = 32'h0000_0000;
        end

        // Command index and register writes
        if (cmd_valid_i) begin
            s_nxt.cmd = cmd_byte_i;
        end
        if (wr_valid_i) begin
            unique case (s_r.cmd)
                CMD_CFG_WR:   s_nxt.cfg      = wr_data_i[7:5];
                CMD_RATE_WR:  s_nxt.rate     = wr_data_i[3:0];
                CMD_LHI_WR:   s_nxt.lhi      = wr_data_i;
                CMD_LLO_WR:   s_nxt.llo      = wr_data_i;
                CMD_RHI_WR:   s_nxt.rhi      = wr_data_i;
                CMD_RLO_WR:   s_nxt.rlo      = wr_data_i;
                CMD_REM_OT_B: s_nxt.rem_ot_b = wr_data_i;
                CMD_LOC_OT_B: s_nxt.loc_ot_b = wr_data_i;
                CMD_REM_OT_A: s_nxt.rem_ot_a = wr_data_i;
                CMD_LOC_OT_A: s_nxt.loc_ot_a = wr_data_i;
                CMD_OVERTEMP_HYSTERESIS:     s_nxt.overtemp_hysteresis     = wr_data_i;
                default:      s_nxt.overtemp_hysteresis     = s_r.overtemp_hysteresis;
            endcase
        end

        // Read mux, registered onto the data port
        unique case (s_r.cmd)
            CMD_LOCAL_TEMP:  rdv = s_r.loc;
            CMD_REMOTE_TEMP: rdv = s_r.rem;
            CMD_STATUS:      rdv = status;
            CMD_CFG_RD:      rdv = {s_r.cfg, 5'b0_0000};
            CMD_RATE_RD:     rdv = {4'h0, s_r.rate};
            CMD_LHI_RD:      rdv = s_r.lhi;
            CMD_LLO_RD:      rdv = s_r.llo;
            CMD_RHI_RD:      rdv = s_r.rhi;
            CMD_RLO_RD:      rdv = s_r.rlo;
            CMD_REMOTE_FRAC: rdv = s_r.rem_x;
            CMD_LOCAL_FRAC:  rdv = s_r.loc_x;
            CMD_REM_OT_B:    rdv = s_r.rem_ot_b;
            CMD_LOC_OT_B:    rdv = s_r.loc_ot_b;
            CMD_REM_OT_A:    rdv = s_r.rem_ot_a;
            CMD_LOC_OT_A:    rdv = s_r.loc_ot_a;
            CMD_OVERTEMP_HYSTERESIS:        rdv = s_r.overtemp_hysteresis;
            CMD_MAKER:       rdv = MAKER_ID;
            default:         rdv = 8'h00;
        endcase
        if (rd_req_i) begin
            s_nxt.rd_data = rdv;
        end else if (ara_req_i && s_r.alert) begin
            s_nxt.rd_data = {slave_addr_i, 1'b0};
        end

        // Clears first, then the conversion-end sets, so a set is never lost
        if (rd_req_i && s_r.cmd == CMD_STATUS) begin
            s_nxt.flags = s_r.flags & s_r.cause;
            s_nxt.alert = 1'b0;
        end
        if (ara_done_i && !ara_lost_i && s_r.alert) begin
            s_nxt.alert = 1'b0;
        end
        if (done_evt) begin
            s_nxt.flags = s_nxt.flags | cause_new;
            if (|cause_new && !s_r.cfg[CFG_MASK]) begin
                s_nxt.alert = 1'b1;
            end
        end

        // Overheat flags track stored results and live limits
        if (s_r.done_seen) begin
            s_nxt.ot[0] = ot_next(s_r.ot[0], s_r.loc, s_r.loc_ot_a, s_r.overtemp_hysteresis);
            s_nxt.ot[1] = ot_next(s_r.ot[1], s_r.rem, s_r.rem_ot_a, s_r.overtemp_hysteresis);
            s_nxt.ot[2] = ot_next(s_r.ot[2], s_r.loc, s_r.loc_ot_b, s_r.overtemp_hysteresis);
            s_nxt.ot[3] = ot_next(s_r.ot[3], s_r.rem, s_r.rem_ot_b, s_r.overtemp_hysteresis);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================================
    // Outputs
    assign rd_data_o           = s_r.rd_data;
    assign ara_ack_o           = ara_req_i && s_r.alert;
    assign conv_start_o        = s_r.start;
    assign junction_type_sel_o = s_r.cfg[CFG_JTYP];
    assign alert_o             = 1'b0;
    assign alert_oe_o          = !s_r.alert;
    assign overheat_out_a_o    = s_r.ot[0] || s_r.ot[1];
    assign overheat_out_b_o    = s_r.ot[2] || s_r.ot[3];

endmodule // temp_alarm_register_logic

/* include/temp_alarm_pkg.sv */
// Function
// - Remote junction fault loads fixed fault code
// - Open junction sets status bit 2, alert
// - No fault reported before first conversion ends
// - Main results two's complement, saturate at 127
// - Separate high/low limits; high limit inclusive alert
// - High limits reset +70, low limits -55
// - Overheat asserts at or above threshold, resets +85
// - Overheat releases below threshold minus hysteresis
// - Alert latched; cleared by status read or response
// - Conversions stop only in standby; one alert per conversion
// - Fraction in top three bits, 0.125 steps
// - Alert response returns own slave address
// - Lost arbitration: no acknowledge, alert kept low
// - Command index resets to zero
// - Distinct read and write codes for config, rate and alert limits; overheat limits and hysteresis share one code
// - One-shot starts conversion; standby resumes afterward
// - One-shot ignored while conversion running
// - One-shot between conversions restarts rate timer
// - Config bits: 7 mask, 6 standby, 5 junction
// - Config bits 0 to 4 read zero
// - Status resets with busy set, flags clear
// - Status read clears bits 2-6 unless persisting
// - Status bit layout busy down to local overheat
// - Overheat status bits ignore status reads
// - Rate uses four bits, doubling, resets 08h
package temp_alarm_pkg;

    // =====================================================================
    // Command codes
    localparam logic [7:0] CMD_LOCAL_TEMP   = 8'h00;
    localparam logic [7:0] CMD_REMOTE_TEMP  = 8'h01;
    localparam logic [7:0] CMD_STATUS       = 8'h02;
    localparam logic [7:0] CMD_CFG_RD       = 8'h03;
    localparam logic [7:0] CMD_RATE_RD      = 8'h04;
    localparam logic [7:0] CMD_LHI_RD       = 8'h05;
    localparam logic [7:0] CMD_LLO_RD       = 8'h06;
    localparam logic [7:0] CMD_RHI_RD       = 8'h07;
    localparam logic [7:0] CMD_RLO_RD       = 8'h08;
    localparam logic [7:0] CMD_CFG_WR       = 8'h09;
    localparam logic [7:0] CMD_RATE_WR      = 8'h0A;
    localparam logic [7:0] CMD_LHI_WR       = 8'h0B;
    localparam logic [7:0] CMD_LLO_WR       = 8'h0C;
    localparam logic [7:0] CMD_RHI_WR       = 8'h0D;
    localparam logic [7:0] CMD_RLO_WR       = 8'h0E;
    localparam logic [7:0] CMD_ONE_SHOT     = 8'h0F;
    localparam logic [7:0] CMD_REMOTE_FRAC  = 8'h10;
    localparam logic [7:0] CMD_LOCAL_FRAC   = 8'h11;
    localparam logic [7:0] CMD_REM_OT_B     = 8'h16;
    localparam logic [7:0] CMD_LOC_OT_B     = 8'h17;
    localparam logic [7:0] CMD_REM_OT_A     = 8'h19;
    localparam logic [7:0] CMD_LOC_OT_A     = 8'h20;
    localparam logic [7:0] CMD_OVERTEMP_HYSTERESIS         = 8'h21;
    localparam logic [7:0] CMD_MAKER        = 8'hFE;

    // =====================================================================
    // Reset values and fixed codes
    localparam logic [7:0] RST_CMD          = 8'h00;
    localparam logic [2:0] RST_CFG          = 3'h1;
    localparam logic [3:0] RST_RATE         = 4'h8;
    localparam logic [7:0] RST_HIGH_LIMIT   = 8'h46;
    localparam logic [7:0] RST_LOW_LIMIT    = 8'hC9;
    localparam logic [7:0] RST_OT_LIMIT     = 8'h55;
    localparam logic [7:0] RST_OVERTEMP_HYSTERESIS         = 8'h0A;
    localparam logic [7:0] FAULT_CODE       = 8'h80;
    localparam logic [7:0] MAIN_MAX         = 8'h7F;
    localparam logic [7:0] MAIN_MIN         = 8'h80;
    localparam logic [3:0] RATE_FASTEST     = 4'h8;
    localparam int         FRAC_BITS        = 3;

    // Config field positions inside the 3-bit stored config (bits 7:5)
    localparam int CFG_MASK = 2;
    localparam int CFG_STBY = 1;
    localparam int CFG_JTYP = 0;
    // Sticky flag positions (status bits 6:2)
    localparam int FL_LHI  = 4;
    localparam int FL_LLO  = 3;
    localparam int FL_RHI  = 2;
    localparam int FL_RLO  = 1;
    localparam int FL_OPEN = 0;

    // =====================================================================
    // Timing: interval at the fastest rate (16 Hz)
    localparam int CLK_MHZ           = 100;
    localparam int FAST_PERIOD_US    = 62500;
    localparam int FAST_PERIOD_CYC   = FAST_PERIOD_US * CLK_MHZ;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;

    typedef struct packed {
        conv_state_t conv;
        logic        start;
        logic [31:0] timer;
        logic [7:0]  cmd;
        logic [7:0]  loc;
        logic [7:0]  rem;
        logic [7:0]  loc_x;
        logic [7:0]  rem_x;
        logic [2:0]  cfg;
        logic [3:0]  rate;
        logic [7:0]  lhi;
        logic [7:0]  llo;
        logic [7:0]  rhi;
        logic [7:0]  rlo;
        logic [7:0]  rem_ot_a;
        logic [7:0]  loc_ot_a;
        logic [7:0]  rem_ot_b;
        logic [7:0]  loc_ot_b;
        logic [7:0]  overtemp_hysteresis;
        logic [4:0]  flags;
        logic [4:0]  cause;
        logic [3:0]  ot;
        logic        alert;
        logic        done_seen;
        logic [7:0]  rd_data;
    } state_t;

endpackage

/* verification/temp_alarm_checker.sv */
`timescale 1ns/10ps
module temp_alarm_checker (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic [6:0] slave_addr_i,
    input wire logic       wr_valid_i,
    input wire logic       rd_req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       ara_req_i,
    input wire logic       ara_ack_o,
    input wire logic       ara_lost_i,
    input wire logic       ara_done_i,
    input wire logic       conv_start_o,
    input wire logic       junction_type_sel_o,
    input wire logic       conv_done_i,
    input wire logic       alert_oe_o
);
    // ====================
    // Alert response steps
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence ara_taken;
        ara_req_i && ara_ack_o;
    endsequence
    sequence addr_shown;
        rd_data_o == {$past(slave_addr_i), 1'b0};
    endsequence
    ack_needs_alert_a: assert property (ara_ack_o |-> ara_req_i && !alert_oe_o)
        else $error("ack without request or latched alert");
    ack_when_latched_a: assert property (ara_req_i && !alert_oe_o |-> ara_ack_o)
        else $error("latched alert not acknowledged");
    ara_addr_out_a: assert property (ara_taken |=> addr_shown)
        else $error("alert response byte wrong");
    ara_clears_a: assert property (ara_done_i && !ara_lost_i && !conv_done_i |=> alert_oe_o)
        else $error("alert not cleared by response");
    lost_keeps_a: assert property (ara_lost_i && !alert_oe_o && !rd_req_i |=> !alert_oe_o)
        else $error("alert released after lost arbitration");
    // ====================
    // Conversion side
    alert_on_conv_a: assert property ($fell(alert_oe_o) |-> $past(conv_done_i))
        else $error("alert raised outside conversion end");
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    jtype_by_write_a: assert property ($changed(junction_type_sel_o) |-> $past(wr_valid_i))
        else $error("junction type changed without write");
    rdata_holds_a: assert property ($changed(rd_data_o) |-> $past(rd_req_i) || $past(ara_req_i))
        else $error("read data changed without request");
endmodule // temp_alarm_checker

bind temp_alarm_register_logic temp_alarm_checker u_checker (.clk_i, .rst_b_i, .slave_addr_i,
    .wr_valid_i, .rd_req_i, .rd_data_o, .ara_req_i, .ara_ack_o, .ara_lost_i, .ara_done_i,
    .conv_start_o, .junction_type_sel_o, .conv_done_i, .alert_oe_o);

/* verification/conv_model.sv */
`timescale 1ns/10ps
module conv_model #(
    parameter int DLY = 20
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic conv_start_i,
    output logic      conv_done_o
);
    int cnt;
    // A conversion is already under way when reset lifts
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= DLY;
            conv_done_o <= 1'b0;
        end else begin
            if (conv_start_i) cnt <= DLY;
            else if (cnt > 0) cnt <= cnt - 1;
            conv_done_o <= (cnt == 1) && !conv_start_i;
        end
    end
endmodule // conv_model

/* verification/temp_alarm_register_logic_tb.sv */
`timescale 1ns/10ps
module temp_alarm_register_logic_tb;
    import temp_alarm_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
    localparam logic [6:0] SLV   = 7'h2B;
    logic        clk_i, rst_b_i, cmd_valid, wr_valid, rd_req, ara_req, ara_lost, ara_done;
    logic        ara_ack, conv_start, jsel, conv_done, r_open, r_short, alert, alert_oe;
    logic        ovh_a, ovh_b;
    logic [7:0]  cmd_byte, wr_data, rd_data;
    logic [11:0] local_t, remote_t;
    int          n_errors, samples_checked, n_starts, n, i;
    logic [7:0]  rc [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h16, 8'h17, 8'h19,
                             8'h20, 8'h21, 8'h30, 8'hFE};
    logic [7:0]  re [13] = '{8'h20, 8'h08, 8'h46, 8'hC9, 8'h46, 8'hC9, 8'h55, 8'h55, 8'h55,
                             8'h55, 8'h0A, 8'h00, MAKER};

    temp_alarm_register_logic #(.FAST_INTERVAL(40), .MAKER_ID(MAKER)) u_temp_alarm_register_logic (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .slave_addr_i(SLV), .cmd_valid_i(cmd_valid),
        .cmd_byte_i(cmd_byte), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .rd_req_i(rd_req),
        .rd_data_o(rd_data), .ara_req_i(ara_req), .ara_ack_o(ara_ack), .ara_lost_i(ara_lost),
        .ara_done_i(ara_done), .conv_start_o(conv_start), .junction_type_sel_o(jsel),
        .conv_done_i(conv_done), .local_temp_i(local_t), .remote_temp_i(remote_t),
        .remote_open_i(r_open), .remote_short_i(r_short), .alert_o(alert),
        .alert_oe_o(alert_oe), .overheat_out_a_o(ovh_a), .overheat_out_b_o(ovh_b));
    conv_model #(.DLY(20)) u_conv_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .conv_start_i(conv_start), .conv_done_o(conv_done));

    // ====================
    // Access tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        @(posedge clk_i);
        #1;
        cmd_valid = 1;
        cmd_byte = c;
        @(posedge clk_i);
        #1;
        cmd_valid = 0;
    endtask
    task automatic rcv(input logic [7:0] e, input logic [7:0] m = 8'hFF);
        rd_req = 1;
        @(posedge clk_i);
        #1;
        rd_req = 0;
        chk(rd_data & m, e);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        cmd(c);
        rcv(e, m);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        cmd(c);
        wr_valid = 1;
        wr_data = d;
        @(posedge clk_i);
        #1;
        wr_valid = 0;
    endtask
    // Bounded wait for a conversion end, then let results and overheat settle
    task automatic conv_wait;
        i = 0;
        do begin
            @(posedge clk_i);
            #1;
            i++;
        end while (conv_done !== 1'b1 && i < 200);
        if (i >= 200) n_errors++;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic next_start(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (conv_start !== 1'b1 && k < 200);
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (conv_start === 1'b1) n_starts++;
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        wrap_up;
    end

    // ====================
    // Scenarios
    initial begin
        {rst_b_i, cmd_valid, wr_valid, rd_req, ara_req, ara_lost, ara_done, r_short} = '0;
        {cmd_byte, wr_data, local_t, remote_t} = '0;
        {n_errors, samples_checked, n_starts} = '0;
        r_open = 1;
        repeat (8) @(posedge clk_i);
        #1;
        rst_b_i = 1;
        rcv(8'h00);
        rd(8'h02, 8'h80);
        r_open = 0;
        foreach (rc[k]) rd(rc[k], re[k]);
        wr(8'h09, 8'hFF);
        rd(8'h03, 8'hE0);
        chk({7'h00, jsel}, 8'h01);
        wr(8'h09, 8'h1F);
        rd(8'h03, 8'h00);
        chk({7'h00, jsel}, 8'h00);
        wr(8'h0A, 8'hF5);
        rd(8'h04, 8'h05);
        wr(8'h0A, 8'h08);
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h46);
        local_t = 12'h0C9;
        remote_t = 12'h410;
        conv_wait;
        rd(8'h00, 8'h19);
        rd(8'h11, 8'h20);
        rd(8'h01, 8'h7F);
        chk({alert, alert_oe, ovh_a, ovh_b}, 8'h03);
        rd(8'h02, 8'h12, 8'h7F);
        remote_t = 12'h280;
        conv_wait;
        chk({7'h00, ovh_a}, 8'h01);
        rd(8'h02, 8'h12, 8'h7F);
        remote_t = 12'h0F0;
        conv_wait;
        chk({7'h00, ovh_a}, 8'h00);
        rd(8'h02, 8'h10, 8'h7F);
        rd(8'h02, 8'h00, 8'h7F);
        chk({7'h00, alert_oe}, 8'h01);
        local_t = 12'hE48;
        conv_wait;
        chk({7'h00, alert_oe}, 8'h00);
        ara_req = 1;
        #1;
        chk({7'h00, ara_ack}, 8'h01);
        @(posedge clk_i);
        #1;
        ara_req = 0;
        chk(rd_data, {SLV, 1'b0});
        ara_lost = 1;
        @(posedge clk_i);
        #1;
        ara_lost = 0;
        chk({7'h00, alert_oe}, 8'h00);
        ara_done = 1;
        @(posedge clk_i);
        #1;
        ara_done = 0;
        chk({7'h00, alert_oe}, 8'h01);
        rd(8'h02, 8'h20, 8'h7F);
        local_t = 12'h0C9;
        r_open = 1;
        conv_wait;
        rd(8'h01, 8'h80);
        rd(8'h10, 8'h00);
        chk({7'h00, alert_oe}, 8'h00);
        rd(8'h02, 8'h04, 8'h04);
        r_open = 0;
        r_short = 1;
        conv_wait;
        rd(8'h01, 8'h80);
        rd(8'h02, 8'h04, 8'h04);
        rd(8'h02, 8'h00, 8'h04);
        r_short = 0;
        wr(8'h09, 8'h40);
        repeat (60) @(posedge clk_i);
        n = n_starts;
        repeat (100) @(posedge clk_i);
        chk(8'(n_starts - n), 8'h00);
        cmd(8'h0F);
        cmd(8'h0F);
        repeat (100) @(posedge clk_i);
        chk(8'(n_starts - n), 8'h01);
        wr(8'h09, 8'h00);
        conv_wait;
        cmd_valid = 1;
        cmd_byte = 8'h0F;
        next_start(n);
        cmd_valid = 0;
        next_start(n);
        chk(8'(n), 8'h28);
        wrap_up;
    end
endmodule // temp_alarm_register_logic_tb
